/* File: shared/irq_flags_pkg.sv */
// constants, field positions and carrier types of the interrupt flag block
// assumes a single aclk domain and a 32-bit AXI4-Lite register bus
`default_nettype none

package irq_flags_pkg;

  // ==========================================================================
  // register byte addresses (one aligned word each, data in bits 7:0)
  localparam logic [7:0] ADDR_IRQ_CONTROL  = 8'h00; // core enables and flags
  localparam logic [7:0] ADDR_PERIPH_EN    = 8'h04; // peripheral enables
  localparam logic [7:0] ADDR_PERIPH_FLAG  = 8'h08; // peripheral flags
  localparam logic [7:0] ADDR_RESET_CAUSE  = 8'h0c; // reset cause status
  localparam logic [7:0] ADDR_PORT_MASK    = 8'h10; // per-pin change mask
  localparam logic [7:0] ADDR_EDGE_SELECT  = 8'h14; // external edge option

  // ==========================================================================
  // irq_control field positions
  localparam int IC_GLOBAL    = 7; // global_irq_enable
  localparam int IC_PERIPH    = 6; // periph_gate_enable
  localparam int IC_T0_EN     = 5; // timer0_ovf_enable
  localparam int IC_EXT_EN    = 4; // ext_pin_irq_enable
  localparam int IC_PORT_EN   = 3; // port_change_enable
  localparam int IC_T0_FLAG   = 2; // timer0_ovf_flag
  localparam int IC_EXT_FLAG  = 1; // ext_pin_irq_flag
  localparam int IC_PORT_FLAG = 0; // port_change_flag

  // peripheral enable / flag field positions (same layout in both)
  localparam int PB_ADC     = 6; // adc done
  localparam int PB_CAPCOMP = 5; // capture / compare
  localparam int PB_CMP2    = 4; // comparator 2 change
  localparam int PB_CMP1    = 3; // comparator 1 change
  localparam int PB_TMR2    = 1; // timer2 period match
  localparam int PB_TMR1    = 0; // timer1 overflow

  // implemented peripheral bits, full and reduced variant
  localparam logic [7:0] PERIPH_FULL_MASK    = 8'h7b;
  localparam logic [7:0] PERIPH_REDUCED_MASK = 8'h19;

  // reset cause field positions
  localparam int RC_POWER_ON = 1; // power-on status
  localparam int RC_BROWNOUT = 0; // brownout_status

  // ==========================================================================
  // reset values
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPH_RST      = 8'h00;
  localparam logic [1:0] RESET_CAUSE_RST = 2'h0; // both causes read as 0
  localparam logic [5:0] PORT_MASK_RST   = 6'h00;
  localparam logic       EDGE_SELECT_RST = 1'b1; // rising edge after reset

  // ==========================================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // capture/compare unit mode as reported by the timer1 logic
  typedef enum logic [1:0] {
    CCP_OFF, CCP_CAPTURE, CCP_COMPARE, CCP_PWM
  } capcomp_mode_t;

  // event and level inputs from the surrounding peripherals
  typedef struct packed {
    logic          timer0_rollover; // pulse: timer0_count wrapped
    logic          ext_irq_pin;     // level of ext_irq_pin
    logic [5:0]    io_port_pins;    // levels of io_port_pins 5:0
    logic          adc_done;        // pulse: conversion complete
    capcomp_mode_t capcomp_mode;    // current capture/compare mode
    logic          capcomp_event;   // pulse: capture or compare match
    logic          cmp2_out;        // level: comparator 2 output
    logic          cmp1_out;        // level: comparator 1 output
    logic          timer2_match;    // pulse: timer2 equals timer2_period
    logic          timer1_ovf;      // pulse: timer1 overflow
    logic          brownout_reset;  // pulse: brown-out reset happened
    logic          brownout_enable; // level: brown-out reset enabled
  } irq_events_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0] irq_control;  // core enables and flags
    logic [7:0] periph_en;    // peripheral enables
    logic [7:0] periph_flag;  // peripheral flags
    logic [1:0] reset_cause;  // power-on and brown-out status
    logic [5:0] port_mask;    // port_change_mask
    logic       edge_sel;     // ext_edge_select
    logic       ext_prev;     // last ext pin level
    logic [5:0] port_prev;    // last port levels
    logic       cmp2_prev;    // last comparator 2 level
    logic       cmp1_prev;    // last comparator 1 level
    logic       irq_request;  // request to the core
    logic       aw_held;      // write address captured
    logic       w_held;       // write data captured
    logic [7:0] waddr;        // captured write address
    logic [7:0] wdata;        // captured write data byte
    logic       wstrb0;       // captured lane 0 strobe
    logic       awready;      // write address ready
    logic       wready;       // write data ready
    logic       bvalid;       // write response valid
    logic [1:0] bresp;        // write response code
    logic       arready;      // read address ready
    logic       rvalid;       // read data valid
    logic [7:0] rdata;        // read data byte
    logic [1:0] rresp;        // read response code
  } state_t;

endpackage

`default_nettype wire

/* File: hdl/irq_flags.sv */
// interrupt enable/flag registers, request logic and reset cause status
// assumes inputs synchronous to aclk and an AXI4-Lite master that keeps
// valid and payload stable until ready
`timescale 1ns/100ps
`default_nettype none

module irq_flags #(
  parameter logic FULL_VARIANT = 1'b1 // 0: no adc, capcomp, timer2
) (
  input  wire logic                       aclk,          // core clock
  input  wire logic                       aresetn,       // sync reset, low
  input  wire logic [7:0]                 s_axi_awaddr,  // write address
  input  wire logic                       s_axi_awvalid, // address valid
  output var  logic                       s_axi_awready, // address ready
  input  wire logic [31:0]                s_axi_wdata,   // write data
  input  wire logic [3:0]                 s_axi_wstrb,   // byte strobes
  input  wire logic                       s_axi_wvalid,  // data valid
  output var  logic                       s_axi_wready,  // data ready
  output var  logic [1:0]                 s_axi_bresp,   // write response
  output var  logic                       s_axi_bvalid,  // response valid
  input  wire logic                       s_axi_bready,  // response ready
  input  wire logic [7:0]                 s_axi_araddr,  // read address
  input  wire logic                       s_axi_arvalid, // address valid
  output var  logic                       s_axi_arready, // address ready
  output var  logic [31:0]                s_axi_rdata,   // read data
  output var  logic [1:0]                 s_axi_rresp,   // read response
  output var  logic                       s_axi_rvalid,  // read valid
  input  wire logic                       s_axi_rready,  // read ready
  input  wire irq_flags_pkg::irq_events_t ev,            // peripheral events
  output var  logic                       irq_request    // request to core
);

  // ==========================================================================
  // implemented peripheral bits for this variant
  // full or reduced variant mask, chosen by FULL_VARIANT
  localparam logic [7:0] PERIPH_IMPL = FULL_VARIANT ?
    irq_flags_pkg::PERIPH_FULL_MASK : irq_flags_pkg::PERIPH_REDUCED_MASK;

  irq_flags_pkg::state_t s_q; // registered state
  irq_flags_pkg::state_t s_d; // next state

  // ==========================================================================
  // request decision, used by the next-state logic
  function automatic logic pending(input irq_flags_pkg::state_t s);
    logic [7:0] c;
    logic       core_hit;
    logic       periph_hit;
    c = s.irq_control;
    // core enables pair with their flags
    core_hit = (c[irq_flags_pkg::IC_T0_EN] & c[irq_flags_pkg::IC_T0_FLAG])
             | (c[irq_flags_pkg::IC_EXT_EN] & c[irq_flags_pkg::IC_EXT_FLAG])
             | (c[irq_flags_pkg::IC_PORT_EN]
                & c[irq_flags_pkg::IC_PORT_FLAG]);
    // peripheral gate in front of all peripheral sources
    periph_hit = c[irq_flags_pkg::IC_PERIPH]
               & (|(s.periph_en & s.periph_flag));
    pending = c[irq_flags_pkg::IC_GLOBAL] & (core_hit | periph_hit);
  endfunction

  // ==========================================================================
  // read decode: byte in low bits, bit 8 marks an unmapped address
  function automatic logic [8:0] read_reg(
    input irq_flags_pkg::state_t s,
    input logic [7:0]            addr,
    input logic                  bor_en
  );
    logic [7:0] rc;
    rc = 8'h00;
    // only the two low cause bits exist
    rc[irq_flags_pkg::RC_POWER_ON] = s.reset_cause[irq_flags_pkg::RC_POWER_ON];
    // brown-out status masked while brown-out reset is off
    rc[irq_flags_pkg::RC_BROWNOUT] =
      s.reset_cause[irq_flags_pkg::RC_BROWNOUT] & bor_en;
    case (addr)
      irq_flags_pkg::ADDR_IRQ_CONTROL: read_reg = {1'b0, s.irq_control};
      irq_flags_pkg::ADDR_PERIPH_EN:   read_reg = {1'b0,
                                                   s.periph_en & PERIPH_IMPL};
      irq_flags_pkg::ADDR_PERIPH_FLAG: read_reg = {1'b0,
                                                   s.periph_flag & PERIPH_IMPL};
      irq_flags_pkg::ADDR_RESET_CAUSE: read_reg = {1'b0, rc};
      irq_flags_pkg::ADDR_PORT_MASK:   read_reg = {3'h0, s.port_mask};
      irq_flags_pkg::ADDR_EDGE_SELECT: read_reg = {8'h00, s.edge_sel};
      default:                         read_reg = 9'h100;
    endcase
  endfunction

  // ==========================================================================
  // next state: bus slave, software writes, then hardware events on top
  always_comb begin
    logic       do_write;   // both write halves held, response free
    logic       ext_edge;   // qualified edge on the external pin
    logic [5:0] port_diff;  // masked pin changes
    logic [8:0] rd;         // read decode result
    do_write  = 1'b0;
    ext_edge  = 1'b0;
    port_diff = 6'h00;
    rd        = 9'h000;
    s_d       = s_q;

    // write address and data are taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = s_axi_wdata[7:0];
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    // retire a finished write response
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // the write acts one cycle after both halves are in
    do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    if (do_write) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = irq_flags_pkg::RESP_OKAY;
      case (s_q.waddr)
        irq_flags_pkg::ADDR_IRQ_CONTROL: begin
          // flags are writable so software clears them here
          if (s_q.wstrb0) begin
            s_d.irq_control = s_q.wdata;
          end
        end
        irq_flags_pkg::ADDR_PERIPH_EN: begin
          if (s_q.wstrb0) begin
            s_d.periph_en = s_q.wdata & PERIPH_IMPL;
          end
        end
        irq_flags_pkg::ADDR_PERIPH_FLAG: begin
          if (s_q.wstrb0) begin
            s_d.periph_flag = s_q.wdata & PERIPH_IMPL;
          end
        end
        irq_flags_pkg::ADDR_RESET_CAUSE: begin
          // software marks the causes as seen
          if (s_q.wstrb0) begin
            s_d.reset_cause = s_q.wdata[1:0];
          end
        end
        irq_flags_pkg::ADDR_PORT_MASK: begin
          if (s_q.wstrb0) begin
            s_d.port_mask = s_q.wdata[5:0];
          end
        end
        irq_flags_pkg::ADDR_EDGE_SELECT: begin
          if (s_q.wstrb0) begin
            s_d.edge_sel = s_q.wdata[0];
          end
        end
        default: begin
          // unmapped: nothing stored, error answered
          s_d.bresp = irq_flags_pkg::RESP_SLVERR;
        end
      endcase
    end

    // reads see the state before this cycle's updates
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      rd         = read_reg(s_q, s_axi_araddr, ev.brownout_enable);
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd[7:0];
      s_d.rresp  = rd[8] ? irq_flags_pkg::RESP_SLVERR
                         : irq_flags_pkg::RESP_OKAY;
    end

    // hardware sets are or-ed after the write, so an event in the
    // cycle of a clearing write survives
    // edge select picks the polarity
    ext_edge = s_q.edge_sel ? (ev.ext_irq_pin && !s_q.ext_prev)
                            : (!ev.ext_irq_pin && s_q.ext_prev);
    // only masked pins count as a change
    port_diff = (ev.io_port_pins ^ s_q.port_prev) & s_q.port_mask;
    if (ev.timer0_rollover) begin
      s_d.irq_control[irq_flags_pkg::IC_T0_FLAG] = 1'b1;
    end
    if (ext_edge) begin
      s_d.irq_control[irq_flags_pkg::IC_EXT_FLAG] = 1'b1;
    end
    if (|port_diff) begin
      s_d.irq_control[irq_flags_pkg::IC_PORT_FLAG] = 1'b1;
    end
    if (ev.adc_done) begin
      s_d.periph_flag[irq_flags_pkg::PB_ADC] = 1'b1;
    end
    // capture or compare only, pwm leaves the flag alone
    if (ev.capcomp_event
        && (ev.capcomp_mode == irq_flags_pkg::CCP_CAPTURE
            || ev.capcomp_mode == irq_flags_pkg::CCP_COMPARE)) begin
      s_d.periph_flag[irq_flags_pkg::PB_CAPCOMP] = 1'b1;
    end
    if (ev.cmp2_out != s_q.cmp2_prev) begin
      s_d.periph_flag[irq_flags_pkg::PB_CMP2] = 1'b1;
    end
    if (ev.cmp1_out != s_q.cmp1_prev) begin
      s_d.periph_flag[irq_flags_pkg::PB_CMP1] = 1'b1;
    end
    if (ev.timer2_match) begin
      s_d.periph_flag[irq_flags_pkg::PB_TMR2] = 1'b1;
    end
    if (ev.timer1_ovf) begin
      s_d.periph_flag[irq_flags_pkg::PB_TMR1] = 1'b1;
    end
    // absent peripherals never show a flag
    s_d.periph_flag = s_d.periph_flag & PERIPH_IMPL;
    // a brown-out beats a software set in the same cycle
    if (ev.brownout_reset) begin
      s_d.reset_cause[irq_flags_pkg::RC_BROWNOUT] = 1'b0;
    end

    // remember levels for edge and change detection
    s_d.ext_prev  = ev.ext_irq_pin;
    s_d.port_prev = ev.io_port_pins;
    s_d.cmp2_prev = ev.cmp2_out;
    s_d.cmp1_prev = ev.cmp1_out;

    // readies follow from what is held; one write and one read at a time
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready  = !s_d.w_held && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;

    // request registered from the next state
    s_d.irq_request = pending(s_d);

    // power-on reset; levels are sampled so no false change follows
    if (!aresetn) begin
      s_d             = '0;
      s_d.irq_control = irq_flags_pkg::IRQ_CONTROL_RST;
      s_d.periph_en   = irq_flags_pkg::PERIPH_RST;
      s_d.periph_flag = irq_flags_pkg::PERIPH_RST;
      // power-on status reads 0 after power-on
      s_d.reset_cause = irq_flags_pkg::RESET_CAUSE_RST;
      s_d.port_mask   = irq_flags_pkg::PORT_MASK_RST;
      s_d.edge_sel    = irq_flags_pkg::EDGE_SELECT_RST;
      s_d.ext_prev    = ev.ext_irq_pin;
      s_d.port_prev   = ev.io_port_pins;
      s_d.cmp2_prev   = ev.cmp2_out;
      s_d.cmp1_prev   = ev.cmp1_out;
    end
  end

  // ==========================================================================
  // state register, synchronous reset handled above
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // outputs straight from the state flip-flops
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = {24'h000000, s_q.rdata};
  assign irq_request   = s_q.irq_request;

  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a read accepted at a given offset
  sequence seq_read(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence

  // a write that lands on the given offset this cycle
  sequence seq_write(logic [7:0] a);
    s_q.aw_held && s_q.w_held && !s_q.bvalid && s_q.waddr == a;
  endsequence

  a_global_gate: assert property (
    !s_q.irq_control[irq_flags_pkg::IC_GLOBAL] |-> !irq_request)
    else $error("request with global enable off");

  // global on, peripheral gate shut, no core source pending
  a_periph_gate: assert property (
    s_q.irq_control[irq_flags_pkg::IC_PERIPH +: 2] == 2'b10
    && !(|(s_q.irq_control[5:3] & s_q.irq_control[2:0]))
    |-> !irq_request) else $error("peripheral passed a closed gate");

  a_request_raise: assert property (
    s_q.irq_control[irq_flags_pkg::IC_GLOBAL]
    && s_q.irq_control[irq_flags_pkg::IC_T0_EN]
    && s_q.irq_control[irq_flags_pkg::IC_T0_FLAG] |-> irq_request)
    else $error("enabled pending source gave no request");

  // rollover sets the flag whatever the enables
  a_timer0_set: assert property ($past(aresetn)
    && ev.timer0_rollover |=> s_q.irq_control[irq_flags_pkg::IC_T0_FLAG])
    else $error("timer0 rollover lost");

  // rising edge of the external pin while edge select picks rising
  a_ext_edge: assert property ($past(aresetn) && s_q.edge_sel
    && $rose(ev.ext_irq_pin) |=> s_q.irq_control[irq_flags_pkg::IC_EXT_FLAG])
    else $error("rising external edge lost");

  a_port_change: assert property ($past(aresetn)
    && |((ev.io_port_pins ^ $past(ev.io_port_pins)) & s_q.port_mask)
    |=> s_q.irq_control[irq_flags_pkg::IC_PORT_FLAG])
    else $error("port change lost");

  // the timer1 flag falls only through a software write; the cycle after a
  // reset is left out because reset clears every flag
  a_flag_sticky: assert property ($past(aresetn)
    && $fell(s_q.periph_flag[irq_flags_pkg::PB_TMR1])
    |-> $past(s_q.aw_held && s_q.w_held
              && s_q.waddr == irq_flags_pkg::ADDR_PERIPH_FLAG))
    else $error("timer1 flag fell without a write");

  // pwm mode never sets the capture/compare flag
  a_capcomp_pwm: assert property (
    ev.capcomp_mode == irq_flags_pkg::CCP_PWM
    && !s_q.periph_flag[irq_flags_pkg::PB_CAPCOMP]
    && !(s_q.aw_held && s_q.w_held && !s_q.bvalid
         && s_q.waddr == irq_flags_pkg::ADDR_PERIPH_FLAG)
    |=> !s_q.periph_flag[irq_flags_pkg::PB_CAPCOMP])
    else $error("capture flag set in pwm mode");

  a_periph_layout: assert property (
    seq_read(irq_flags_pkg::ADDR_PERIPH_EN)
    |=> s_axi_rvalid && (s_axi_rdata[7:0] & ~PERIPH_IMPL) == 8'h00)
    else $error("unimplemented peripheral bit read one");

  // an enable write keeps only the implemented bits
  a_enable_store: assert property (
    seq_write(irq_flags_pkg::ADDR_PERIPH_EN) ##0 s_q.wstrb0
    |=> s_q.periph_en == ($past(s_q.wdata) & PERIPH_IMPL))
    else $error("peripheral enable write not stored");

  // reset cause read masking; the read shows the old state
  a_cause_read: assert property (
    seq_read(irq_flags_pkg::ADDR_RESET_CAUSE) ##0 !ev.brownout_enable
    |=> s_axi_rdata[7:0] == {6'h00,
    $past(s_q.reset_cause[irq_flags_pkg::RC_POWER_ON]), 1'b0})
    else $error("reset cause read wrong");

  a_brownout_clear: assert property (ev.brownout_reset
    |=> !s_q.reset_cause[irq_flags_pkg::RC_BROWNOUT])
    else $error("brown-out status not cleared");

  // write answered one cycle after both halves are held
  a_write_answer: assert property (
    s_q.aw_held && s_q.w_held && !s_q.bvalid
    |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
    else $error("write not answered");

endmodule

`default_nettype wire

/* File: verif/irq_event_source.sv */
// event source standing in for the peripherals around the flag block
// assumes the bench asks for events; single aclk domain
`timescale 1ns/100ps
`default_nettype none

module irq_event_source (
  input  wire irq_flags_pkg::irq_events_t req, // events asked for
  input  wire logic                       aclk, // core clock
  output var  irq_flags_pkg::irq_events_t ev    // events to the block
);
  // ==========================================================================
  // registered so every event lands just after an edge, never mid-cycle
  always_ff @(posedge aclk) begin
    ev <= req;
  end
endmodule

`default_nettype wire

/* File: verif/irq_flag_enable_and_reset_status_bench.sv */
// self-checking bench of the interrupt flag block
// assumes irq_flags_pkg, irq_flags and irq_event_source compiled first
`timescale 1ns/100ps
`default_nettype none

module irq_flag_enable_and_reset_status_bench;
  // ==========================================================================
  // signals
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid;
  logic rready, awready, wready, arready, irq;
  logic [7:0]  awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  m, t;
  logic [3:0]  ws;
  irq_flags_pkg::irq_events_t req, ev;
  int seed, err_count, n_tests, cyc, i;

  irq_flags dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ev(ev),
    .irq_request(irq));
  irq_event_source peer (.req(req), .aclk(aclk), .ev(ev));

  // ==========================================================================
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end

  // ==========================================================================
  // bus tasks and comparisons
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata[7:0]; r = rresp;
    rready <= 0;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a); chk(d, e);
  endtask
  task automatic st;
    repeat (3) @(posedge aclk);
  endtask
  task automatic ci(input logic e);
    st; chk({7'h0, irq}, {7'h0, e});
  endtask
  // capture/compare pulse in a given mode, flags cleared first
  task automatic ccp(input irq_flags_pkg::capcomp_mode_t md,
                     input logic [7:0] e);
    wr(8'h08, 8'h00);
    req.capcomp_mode <= md;
    req.capcomp_event <= 1;
    @(posedge aclk);
    req.capcomp_event <= 0;
    st;
    rc(8'h08, e);
  endtask
  // port flag expected from mask and toggled pins
  function automatic logic [7:0] exp_port(logic [5:0] mk, logic [5:0] tg);
    return {7'h0, |(mk & tg)};
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // main sequence: reset, layout, flags, gating, edges, random port
  initial begin
    seed = 83; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; ws = 4'hf;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0; req = '0;
    req.brownout_enable = 1; req.capcomp_mode = irq_flags_pkg::CCP_CAPTURE;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (i = 0; i < 6; i++) rc(8'(i * 4), 8'(i == 5));
    rd(8'h18); chk({6'h0, r}, {6'h0, irq_flags_pkg::RESP_SLVERR});
    wr(8'h18, 8'hff);
    chk({6'h0, r}, {6'h0, irq_flags_pkg::RESP_SLVERR});
    // a write with lane 0 off is answered but stores nothing
    ws <= 4'h0;
    wr(8'h10, 8'h3f);
    chk({6'h0, r}, {6'h0, irq_flags_pkg::RESP_OKAY});
    ws <= 4'hf;
    rc(8'h10, 8'h00);
    $display("test reset done");
    wr(8'h04, 8'hff); rc(8'h04, irq_flags_pkg::PERIPH_FULL_MASK);
    wr(8'h0c, 8'hff); rc(8'h0c, 8'h03);
    chk({7'h0, |rdata[31:8]}, 8'h00);
    req.brownout_reset <= 1; @(posedge aclk); req.brownout_reset <= 0;
    st; rc(8'h0c, 8'h02);
    wr(8'h0c, 8'h03); req.brownout_enable <= 0; st; rc(8'h0c, 8'h02);
    $display("test layout done");
    wr(8'h04, 8'h00);
    {req.adc_done, req.capcomp_event, req.timer2_match} <= 3'h7;
    {req.timer1_ovf, req.timer0_rollover, req.cmp1_out, req.cmp2_out} <= 4'hf;
    @(posedge aclk);
    {req.adc_done, req.capcomp_event, req.timer2_match} <= 3'h0;
    {req.timer1_ovf, req.timer0_rollover} <= 2'h0;
    st; rc(8'h08, 8'h7b);
    rc(8'h00, 8'h04);
    wr(8'h00, 8'hc4); ci(0);
    wr(8'h04, 8'h01); ci(1);
    wr(8'h00, 8'h84); ci(0);
    wr(8'h00, 8'ha4); ci(1);
    wr(8'h00, 8'h24); ci(0);
    ccp(irq_flags_pkg::CCP_PWM, 8'h00);
    ccp(irq_flags_pkg::CCP_COMPARE, 8'h20);
    ccp(irq_flags_pkg::CCP_OFF, 8'h00);
    $display("test gating done");
    wr(8'h00, 8'h00); req.ext_irq_pin <= 1;
    st; rc(8'h00, 8'h02);
    wr(8'h00, 8'h00); req.ext_irq_pin <= 0;
    st; rc(8'h00, 8'h00);
    wr(8'h14, 8'h00); req.ext_irq_pin <= 1;
    st; rc(8'h00, 8'h00);
    req.ext_irq_pin <= 0;
    st; rc(8'h00, 8'h02);
    wr(8'h00, 8'h92); ci(1);
    wr(8'h00, 8'h82); ci(0);
    $display("test edge done");
    for (i = 0; i < 8; i++) begin
      m = 6'($random(seed)); t = 6'($random(seed));
      wr(8'h10, {2'h0, m}); wr(8'h00, 8'h00);
      req.io_port_pins <= req.io_port_pins ^ t;
      st; rc(8'h00, exp_port(m, t));
    end
    // reset in mid-run: power-on status and edge select come back
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rc(8'h0c, 8'h00);
    rc(8'h14, 8'h01);
    // flag cleared and its source enabled in one write
    wr(8'h10, 8'h3f); wr(8'h00, 8'h88);
    req.io_port_pins <= req.io_port_pins ^ 6'h01;
    ci(1);
    $display("test port done");
    complete_run;
  end
endmodule

`default_nettype wire
